// ---- inc/servo_pkg.sv ----
// Function
// - position error into the filter saturates to signed 16 bits
// - each coefficient product is 16x16, low 16 bits kept
// - 24-bit integral; top 16 bits shifted right 8, times integral_gain
// - integral product magnitude limited by integral_limit, sign restored
// - derivative product updated per derivative interval, added every sample
// - terms summed to 16 bits; top 8 or 12 bits are the command
// - command byte captured on rising store strobe with port select low
// - busy never stays high longer than 100 us
// - status byte driven while read strobe low with port select low
// - data moves as two-byte words, high byte first, one strobe each
// - command arriving while busy is discarded
// - busy rises after command byte and after second data byte
// - converter output offset binary, zero 80 or 800 hex
// - 8-bit latched word; 12-bit multiplexed with external latch strobes
// - pulse-width variant: 8-bit magnitude PWM plus sign
// - init codes: reset 00, narrow 05, wide 06, home 02
// - interrupt codes 03, 1B, 1A, 20, 21, 1C, 1D with byte counts
// - loop codes: gains 1E, apply 04, trajectory 1F, start 01
// - report codes 08, 0A, 09, 07 four bytes; 0C, 0B, 0D two
// - reset zeroes gains, trajectory; output half scale, 8-bit, home
// - status bits 1..6 show conditions regardless of mask
package servo_pkg;
    localparam logic [7:0] CMD_RESET     = 8'h00;
    localparam logic [7:0] CMD_START     = 8'h01;
    localparam logic [7:0] CMD_HOME      = 8'h02;
    localparam logic [7:0] CMD_INDEX     = 8'h03;
    localparam logic [7:0] CMD_APPLY     = 8'h04;
    localparam logic [7:0] CMD_NARROW    = 8'h05;
    localparam logic [7:0] CMD_WIDE      = 8'h06;
    localparam logic [7:0] CMD_RD_DVEL   = 8'h07;
    localparam logic [7:0] CMD_RD_DPOS   = 8'h08;
    localparam logic [7:0] CMD_RD_IPOS   = 8'h09;
    localparam logic [7:0] CMD_RD_APOS   = 8'h0a;
    localparam logic [7:0] CMD_RD_AVEL   = 8'h0b;
    localparam logic [7:0] CMD_RD_SIGS   = 8'h0c;
    localparam logic [7:0] CMD_RD_ISUM   = 8'h0d;
    localparam logic [7:0] CMD_ERR_STOP  = 8'h1a;
    localparam logic [7:0] CMD_ERR_INT   = 8'h1b;
    localparam logic [7:0] CMD_MASK      = 8'h1c;
    localparam logic [7:0] CMD_CLR_FLAGS = 8'h1d;
    localparam logic [7:0] CMD_GAINS     = 8'h1e;
    localparam logic [7:0] CMD_TRAJ      = 8'h1f;
    localparam logic [7:0] CMD_BRK_ABS   = 8'h20;
    localparam logic [7:0] CMD_BRK_REL   = 8'h21;
    localparam logic [7:0]  ZERO_NARROW = 8'h80;
    localparam logic [11:0] ZERO_WIDE   = 12'h800;
    localparam int BUSY_BIT      = 0;
    localparam int CLK_MHZ       = 100;
    localparam int BUSY_MAX_US   = 100;
    localparam int BUSY_HOLD_CYC = 20;  // well below the 100 us ceiling
    localparam int BUSY_MAX_CYC  = BUSY_MAX_US * CLK_MHZ;
    localparam int SAMPLE_CYC    = 2048;
    localparam int DERIV_DEF     = 1;
    localparam int PWM_STEPS     = 256;
    typedef enum logic [1:0] {
        H_IDLE = 2'b00, H_CMD = 2'b01, H_DATA = 2'b11
    } host_state_t;
endpackage : servo_pkg

// ---- src/servo_pid_host_port.sv ----
module servo_pid_host_port
    import servo_pkg::*;
#(
    parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // host port
    input  wire logic        portSelect_n,
    input  wire logic        readStrobe_n,
    input  wire logic        storeStrobe_n,
    input  wire logic [7:0]  hostDataIn,
    output logic      [7:0]  hostDataOut,
    output logic             hostDataOe_n,
    // loop inputs
    input  wire logic [31:0] errorIn,
    input  wire logic [5:0]  conditions,
    // motor drive
    output logic      [7:0]  dacPort,
    output logic             latchHigh,
    output logic             latchLow,
    output logic             pwmMag,
    output logic             pwmSign,
    // decoded command outputs
    output logic             defineHome,
    output logic             startMotion,
    output logic             armIndex
);
    // strobe synchronisers
    logic [1:0] rdSync_reg, wrSync_reg;
    logic       rdLast_reg, wrLast_reg;
    logic       psSync_reg;
    logic [7:0] dinSync_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            rdSync_reg <= 2'b11;
            wrSync_reg <= 2'b11;
            rdLast_reg <= 1'b1;
            wrLast_reg <= 1'b1;
        end else begin
            rdSync_reg <= {rdSync_reg[0], readStrobe_n};
            wrSync_reg <= {wrSync_reg[0], storeStrobe_n};
            rdLast_reg <= rdSync_reg[1];
            wrLast_reg <= wrSync_reg[1];
        end
        psSync_reg  <= portSelect_n;
        dinSync_reg <= hostDataIn;
    end
    logic wrRise, rdRise, rdLow;
    assign wrRise = wrSync_reg[1] & ~wrLast_reg;
    assign rdRise = rdSync_reg[1] & ~rdLast_reg;
    assign rdLow  = ~rdSync_reg[1];

    // host protocol state
    host_state_t st_reg, st_next;
    logic [7:0]  cmd_reg, cmd_next, hiByte_reg, hiByte_next;
    logic        second_reg, second_next, busy_reg, busy_next;
    logic [13:0] busyCnt_reg, busyCnt_next;
    logic [2:0]  word_reg, word_next;
    logic        wide_reg, wide_next;
    logic [15:0] kp_reg, kp_next, ki_reg, ki_next, kd_reg, kd_next;
    logic [15:0] il_reg, il_next;
    logic [15:0] kpB_reg, kpB_next, kiB_reg, kiB_next, kdB_reg, kdB_next;
    logic [15:0] ilB_reg, ilB_next;
    logic [7:0]  dInt_reg, dInt_next, dIntB_reg, dIntB_next;
    logic [15:0] gainSel_reg, gainSel_next;
    logic [5:0]  mask_reg, mask_next;
    logic        homeP, startP, armP, softRst;
    logic [15:0] wordOut;
    logic [15:0] dataWord;
    logic [23:0] integ_reg;

    always_comb begin
        // word presented on reads: only the integral sum and the signals read (mask) are local
        wordOut = (cmd_reg == CMD_RD_ISUM) ? integ_reg[23:8]
                : (cmd_reg == CMD_RD_SIGS) ? {10'h000, mask_reg} : 16'h0000;
    end
    assign dataWord = {hiByte_reg, dinSync_reg};

    always_comb begin
        st_next = st_reg;
        cmd_next = cmd_reg;
        hiByte_next = hiByte_reg;
        second_next = second_reg;
        busy_next = busy_reg;
        busyCnt_next = busyCnt_reg;
        word_next = word_reg;
        wide_next = wide_reg;
        kp_next = kp_reg;
        ki_next = ki_reg;
        kd_next = kd_reg;
        il_next = il_reg;
        kpB_next = kpB_reg;
        kiB_next = kiB_reg;
        kdB_next = kdB_reg;
        ilB_next = ilB_reg;
        dInt_next = dInt_reg;
        dIntB_next = dIntB_reg;
        gainSel_next = gainSel_reg;
        mask_next = mask_reg;
        homeP = 1'b0;
        startP = 1'b0;
        armP = 1'b0;
        softRst = 1'b0;
        if (busy_reg) begin
            busyCnt_next = busyCnt_reg + 14'd1;
            if (busyCnt_reg >= 14'(BUSY_HOLD_CYC - 1)
                || busyCnt_reg >= 14'(BUSY_MAX_CYC - 1))
                busy_next = 1'b0;
        end
        if (wrRise && !psSync_reg) begin
            if (!busy_reg) begin
                cmd_next = dinSync_reg;
                busy_next = 1'b1;
                busyCnt_next = '0;
                second_next = 1'b0;
                word_next = '0;
                st_next = H_CMD;
                unique case (dinSync_reg)
                    CMD_RESET:  softRst = 1'b1;
                    CMD_NARROW: wide_next = 1'b0;
                    CMD_WIDE:   wide_next = 1'b1;
                    CMD_HOME:   homeP = 1'b1;
                    CMD_INDEX:  armP = 1'b1;
                    CMD_START:  startP = 1'b1;
                    CMD_APPLY: begin
                        kp_next = kpB_reg; ki_next = kiB_reg;
                        kd_next = kdB_reg; il_next = ilB_reg;
                        dInt_next = dIntB_reg;
                    end
                    default: ;
                endcase
            end
        end else if ((wrRise || rdRise) && psSync_reg && st_reg != H_IDLE) begin
            if (!second_reg) begin
                hiByte_next = wrRise ? dinSync_reg : wordOut[7:0];
                second_next = 1'b1;
            end else begin
                second_next = 1'b0;
                busy_next = 1'b1;
                busyCnt_next = '0;
                st_next = H_DATA;
                word_next = word_reg + 3'd1;
                if (wrRise) begin
                    if (cmd_reg == CMD_MASK) mask_next = dataWord[6:1];
                    if (cmd_reg == CMD_GAINS) begin
                        if (word_reg == 3'd0) begin
                            gainSel_next = dataWord;
                            dIntB_next = dataWord[15:8];
                        end else begin
                            // fill only the selected gains, in order
                            if (gainSel_reg[3] && word_reg == 3'd1)
                                kpB_next = dataWord;
                            if (gainSel_reg[2] && word_reg == 3'(1 + gainSel_reg[3]))
                                kiB_next = dataWord;
                            if (gainSel_reg[1] && word_reg == 3'(1 + gainSel_reg[3]
                                + gainSel_reg[2])) kdB_next = dataWord;
                            if (gainSel_reg[0] && word_reg == 3'(1 + gainSel_reg[3]
                                + gainSel_reg[2] + gainSel_reg[1]))
                                ilB_next = dataWord;
                        end
                    end
                end
            end
        end
        if (softRst) begin
            kp_next = '0; ki_next = '0; kd_next = '0; il_next = '0;
            kpB_next = '0; kiB_next = '0; kdB_next = '0; ilB_next = '0;
            dInt_next = '0; dIntB_next = '0; wide_next = 1'b0;
            mask_next = '0; homeP = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= H_IDLE;
            cmd_reg <= '0;
            hiByte_reg <= '0;
            second_reg <= 1'b0;
            busy_reg <= 1'b0;
            busyCnt_reg <= '0;
            word_reg <= '0;
            wide_reg <= 1'b0;
            kp_reg <= '0;
            ki_reg <= '0;
            kd_reg <= '0;
            il_reg <= '0;
            kpB_reg <= '0;
            kiB_reg <= '0;
            kdB_reg <= '0;
            ilB_reg <= '0;
            dInt_reg <= '0;
            dIntB_reg <= '0;
            gainSel_reg <= '0;
            mask_reg <= '0;
        end else begin
            st_reg <= st_next;
            cmd_reg <= cmd_next;
            hiByte_reg <= hiByte_next;
            second_reg <= second_next;
            busy_reg <= busy_next;
            busyCnt_reg <= busyCnt_next;
            word_reg <= word_next;
            wide_reg <= wide_next;
            kp_reg <= kp_next;
            ki_reg <= ki_next;
            kd_reg <= kd_next;
            il_reg <= il_next;
            kpB_reg <= kpB_next;
            kiB_reg <= kiB_next;
            kdB_reg <= kdB_next;
            ilB_reg <= ilB_next;
            dInt_reg <= dInt_next;
            dIntB_reg <= dIntB_next;
            gainSel_reg <= gainSel_next;
            mask_reg <= mask_next;
        end
    end

    // host read drive
    logic [7:0] dout_next;
    logic       oe_next;
    always_comb begin
        oe_next = ~rdLow;
        if (!psSync_reg)
            dout_next = {1'b0, conditions, busy_reg};
        else
            dout_next = second_reg ? hiByte_reg : wordOut[15:8];
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            hostDataOut <= '0; hostDataOe_n <= 1'b1;
            defineHome <= 1'b0; startMotion <= 1'b0; armIndex <= 1'b0;
        end else begin
            hostDataOut <= dout_next; hostDataOe_n <= oe_next;
            defineHome <= homeP; startMotion <= startP; armIndex <= armP;
        end
    end

    // pid filter
    logic [12:0] smp_reg, smp_next;
    logic [7:0]  dCnt_reg, dCnt_next;
    logic [15:0] eSat, ePrev_reg, ePrev_next, dProd_reg, dProd_next;
    logic [23:0] integ_next;
    logic [15:0] u_reg, u_next, iTerm, iMag, pTerm, iTop;
    logic        tick;
    always_comb begin
        if ($signed(errorIn) > 32'sd32767) eSat = 16'h7fff;
        else if ($signed(errorIn) < -32'sd32768) eSat = 16'h8000;
        else eSat = errorIn[15:0];
        tick = (smp_reg == 13'(SAMPLE_CYCLES - 1));
        smp_next = tick ? '0 : smp_reg + 13'd1;
        integ_next = integ_reg; ePrev_next = ePrev_reg;
        dProd_next = dProd_reg; dCnt_next = dCnt_reg; u_next = u_reg;
        pTerm = 16'(kp_reg * eSat);
        iTop = 16'($signed(integ_reg[23:8]) >>> 8);
        iTerm = 16'(iTop * ki_reg);
        iMag = iTerm[15] ? 16'(-iTerm) : iTerm;
        if (iMag > il_reg)
            iMag = il_reg;
        if (iTerm[15]) iMag = 16'(-iMag);
        if (tick) begin
            integ_next = integ_reg + {{8{eSat[15]}}, eSat};
            if (dCnt_reg >= dInt_reg) begin
                dCnt_next = '0;
                dProd_next = 16'((eSat - ePrev_reg) * kd_reg);
                ePrev_next = eSat;
            end else dCnt_next = dCnt_reg + 8'd1;
            u_next = 16'(pTerm + iMag + dProd_reg);
        end
        if (softRst) begin
            integ_next = '0; u_next = '0; dProd_next = '0;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            smp_reg <= '0; integ_reg <= '0; ePrev_reg <= '0;
            dProd_reg <= '0; dCnt_reg <= '0; u_reg <= '0;
        end else begin
            smp_reg <= smp_next; integ_reg <= integ_next;
            ePrev_reg <= ePrev_next; dProd_reg <= dProd_next;
            dCnt_reg <= dCnt_next; u_reg <= u_next;
        end
    end

    // motor outputs: dac port, mux phase, pwm
    logic [11:0] code12;
    logic [7:0]  code8, mag8, pwmCnt_reg, pwmCnt_next, dac_next;
    logic        phase_reg, phase_next, lh_next, ll_next;
    always_comb begin
        code12 = u_reg[15:4] ^ ZERO_WIDE;
        code8  = u_reg[15:8] ^ ZERO_NARROW;
        mag8   = u_reg[15] ? 8'(-u_reg[15:8]) : u_reg[15:8];
        pwmCnt_next = pwmCnt_reg + 8'd1;
        phase_next = ~phase_reg;
        lh_next = 1'b0; ll_next = 1'b0;
        if (wide_reg) begin
            dac_next = phase_reg ? {code12[11:6], 2'b00}
                                 : {code12[5:0], 2'b00};
            lh_next = phase_reg;
            ll_next = ~phase_reg;
        end else dac_next = code8;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            dacPort <= ZERO_NARROW; latchHigh <= 1'b0; latchLow <= 1'b0;
            pwmMag <= 1'b0; pwmSign <= 1'b0; pwmCnt_reg <= '0;
            phase_reg <= 1'b0;
        end else begin
            dacPort <= dac_next; latchHigh <= lh_next; latchLow <= ll_next;
            pwmCnt_reg <= pwmCnt_next; phase_reg <= phase_next;
            pwmMag <= (pwmCnt_reg < mag8);
            pwmSign <= u_reg[15];
        end
    end
endmodule : servo_pid_host_port

// ---- verif/servo_pid_host_port_assertions.sv ----
module servo_pid_host_port_assertions
    import servo_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // host port
    input wire logic       portSelect_n,
    input wire logic       readStrobe_n,
    input wire logic [7:0] hostDataOut,
    input wire logic       hostDataOe_n,
    input wire logic [5:0] conditions,
    // drive and pulses
    input wire logic [7:0] dacPort,
    input wire logic       latchHigh,
    input wire logic       latchLow,
    input wire logic       defineHome,
    input wire logic       startMotion,
    input wire logic       armIndex
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    dac_reset_a: assert property ($fell(rst) |-> dacPort == ZERO_NARROW)
        else $error("drive not at zero code after reset");
    oe_reset_a: assert property ($fell(rst) |-> hostDataOe_n)
        else $error("data bus driven after reset");
    pulse_reset_a: assert property ($fell(rst) |->
        !(defineHome || startMotion || armIndex))
        else $error("command pulse out of reset");
    start_single_a: assert property (startMotion |=> !startMotion [*8])
        else $error("start pulse repeated");
    home_single_a: assert property (defineHome |=> !defineHome [*8])
        else $error("home pulse repeated");
    index_single_a: assert property (armIndex |=> !armIndex [*8])
        else $error("index pulse repeated");
    read_drive_a: assert property (
        (!portSelect_n && !readStrobe_n) [*4] |-> !hostDataOe_n)
        else $error("status not driven during read");
    read_release_a: assert property (readStrobe_n [*6] |-> hostDataOe_n)
        else $error("bus still driven after read");
    status_bits_a: assert property (
        (!hostDataOe_n && !readStrobe_n && !portSelect_n &&
         !$past(portSelect_n, 4) && conditions == $past(conditions, 4))
        |-> hostDataOut[6:1] == conditions)
        else $error("status bits differ from conditions");
    latch_excl_a: assert property (!(latchHigh && latchLow))
        else $error("both latch strobes high");
endmodule : servo_pid_host_port_assertions

bind servo_pid_host_port servo_pid_host_port_assertions chk (
    .clk, .rst, .portSelect_n, .readStrobe_n, .hostDataOut, .hostDataOe_n,
    .conditions, .dacPort, .latchHigh, .latchLow, .defineHome,
    .startMotion, .armIndex
);

// ---- verif/host_model.sv ----
module host_model
    import servo_pkg::*;
(
    // clock
    input  wire logic       clk,
    // host port
    output logic            portSelect_n,
    output logic            readStrobe_n,
    output logic            storeStrobe_n,
    output logic      [7:0] hostDataIn,
    input  wire logic [7:0] hostDataOut,
    input  wire logic       hostDataOe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int timeouts = 0;
    initial begin
        portSelect_n = 1'b1;
        readStrobe_n = 1'b1;
        storeStrobe_n = 1'b1;
        hostDataIn = 8'h5a;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : hold
    task automatic wr(input logic ps, input logic [7:0] b);
        portSelect_n = ps;
        hostDataIn = b;
        storeStrobe_n = 1'b0;
        hold(4);
        storeStrobe_n = 1'b1;
        hold(4);
        hostDataIn = ~b; // released lines lose the byte
    endtask : wr
    task automatic rd(input logic ps, output logic [7:0] b);
        int n;
        n = 0;
        portSelect_n = ps;
        readStrobe_n = 1'b0;
        while (hostDataOe_n !== 1'b0 && n < 10) begin
            hold(1);
            n++;
        end
        if (n == 10) timeouts++;
        hold(1);
        b = hostDataOut;
        readStrobe_n = 1'b1;
        hold(4);
    endtask : rd
    task automatic ready();
        logic [7:0] s;
        int k;
        k = 0;
        do begin
            rd(1'b0, s);
            k++;
        end while (s[BUSY_BIT] !== 1'b0 && k < 30);
        if (k == 30) timeouts++;
    endtask : ready
    task automatic cmd(input logic [7:0] c);
        ready();
        wr(1'b0, c);
    endtask : cmd
    task automatic word(input logic [7:0] hi, input logic [7:0] lo);
        ready();
        wr(1'b1, hi);
        wr(1'b1, lo);
    endtask : word
endmodule : host_model

// ---- verif/servo_pid_host_port_tb.sv ----
module servo_pid_host_port_tb;
    import servo_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 16;
    typedef struct packed {
        logic [31:0] e;
        logic [7:0]  d;
        logic        sg;
        logic [7:0]  m;
    } row_t;
    row_t rows [5] = '{'{32'h0000_0040, 8'hc0, 1'b0, 8'h40},
        '{32'hffff_ffc0, 8'h40, 1'b1, 8'h40},
        '{32'h0010_0000, 8'h7f, 1'b1, 8'h01},
        '{32'hffff_0000, 8'h80, 1'b0, 8'h00},
        '{32'h0000_0000, 8'h80, 1'b0, 8'h00}};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] errorIn = '0;
    logic [5:0]  conditions = '0;
    wire logic   portSelect_n, readStrobe_n, storeStrobe_n, hostDataOe_n;
    wire logic   latchHigh, latchLow, pwmMag, pwmSign;
    wire logic   defineHome, startMotion, armIndex;
    wire logic [7:0] hostDataIn, hostDataOut, dacPort;
    int err_total = 0;
    int tests_run = 0;
    int homeCnt = 0, startCnt = 0, indexCnt = 0;
    servo_pid_host_port #(.SAMPLE_CYCLES(SC)) DUT (.clk, .rst, .portSelect_n,
        .readStrobe_n, .storeStrobe_n, .hostDataIn, .hostDataOut,
        .hostDataOe_n, .errorIn, .conditions, .dacPort, .latchHigh,
        .latchLow, .pwmMag, .pwmSign, .defineHome, .startMotion, .armIndex);
    host_model host (.clk, .portSelect_n, .readStrobe_n, .storeStrobe_n,
        .hostDataIn, .hostDataOut, .hostDataOe_n);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (defineHome === 1'b1) homeCnt++;
        if (startMotion === 1'b1) startCnt++;
        if (armIndex === 1'b1) indexCnt++;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t byte %h want %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chkn(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            err_total++;
            $display("BAD %0t count %0d want %0d", $time, got, exp);
        end
    endtask : chkn
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    initial begin
        #300000;
        err_total++;
        stop_test();
    end
    initial begin
        logic [7:0] b, s;
        int         n;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        chk8(dacPort, ZERO_NARROW);
        $display("test reset done");
        host.cmd(CMD_GAINS);
        host.word(8'h01, 8'h0f);
        host.word(8'h01, 8'h00);
        repeat (3) host.word(8'h00, 8'h00);
        host.cmd(CMD_APPLY);
        foreach (rows[i]) begin
            errorIn = rows[i].e;
            repeat (3 * SC + 8) @(posedge clk);
            #1 chk8(dacPort, rows[i].d);
            chk8({7'h00, pwmSign}, {7'h00, rows[i].sg});
            n = 0;
            repeat (PWM_STEPS) begin
                @(posedge clk);
                #1;
                if (pwmMag === 1'b1) n++;
            end
            chkn(n, rows[i].m);
        end
        $display("test loop rows done");
        conditions = 6'h2d;
        host.ready();
        host.rd(1'b0, s);
        chk8(s & 8'h7f, 8'h5a);
        $display("test status done");
        host.cmd(CMD_HOME);
        host.rd(1'b0, s);
        chk8(s & 8'h01, 8'h01);
        host.wr(1'b0, CMD_START);
        host.ready();
        chkn(startCnt, 0);
        chkn(homeCnt, 1);
        host.cmd(CMD_START);
        host.cmd(CMD_INDEX);
        host.ready();
        chkn(startCnt, 1);
        chkn(indexCnt, 1);
        $display("test busy and commands done");
        host.cmd(CMD_MASK);
        host.word(8'h00, 8'h7e);
        host.rd(1'b0, s);
        chk8(s & 8'h01, 8'h01);
        host.cmd(CMD_RD_SIGS);
        host.ready();
        host.rd(1'b1, b);
        host.rd(1'b1, s);
        chk8(b, 8'h00);
        chk8(s, 8'h3f);
        $display("test data word done");
        host.cmd(CMD_WIDE);
        host.ready();
        repeat (4) begin
            @(posedge clk);
            #1;
            if (latchHigh === 1'b1) chk8(dacPort & 8'hfc, 8'h80);
            else chk8(dacPort & 8'hfc, 8'h00);
            chk8({7'h00, latchLow}, {7'h00, ~latchHigh});
        end
        host.cmd(CMD_NARROW);
        host.ready();
        chk8(dacPort, ZERO_NARROW);
        $display("test output modes done");
        host.cmd(CMD_RESET);
        host.ready();
        errorIn = 32'h0000_0040;
        repeat (3 * SC + 8) @(posedge clk);
        #1 chk8(dacPort, ZERO_NARROW);
        chkn(host.timeouts, 0);
        $display("test reset command done");
        // only ki and il loaded: output settles at the integral limit
        errorIn = 32'h0000_7fff;
        host.cmd(CMD_GAINS);
        host.word(8'h00, 8'h05);
        host.word(8'h01, 8'h00);
        host.word(8'h10, 8'h00);
        host.cmd(CMD_APPLY);
        repeat (80 * SC) @(posedge clk);
        #1 chk8(dacPort, 8'h90);
        chkn(host.timeouts, 0);
        $display("test integral limit done");
        stop_test();
    end
endmodule : servo_pid_host_port_tb
